// ===== fcs_front_model.sv
// Analog front end model: four track/holds and the comparator
`default_nettype none
`include "fcs_params.svh"

module fcs_front_model (
    input wire logic clk_sys, // System clock
    input wire logic holdMode, // Holds frozen while high
    input wire logic [1:0] muxSel, // Channel under conversion
    input wire logic [`FCS_RES_BITS-1:0] dacCode, // Trial level, offset binary
    input wire logic [`FCS_CHANNELS-1:0][`FCS_RES_BITS-1:0] levelIn, // Live inputs
    output logic compHigh // Held level at or above trial
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [`FCS_CHANNELS-1:0][`FCS_RES_BITS-1:0] heldLevel;
    logic holdPrev = 1'b0;
    logic noise = 1'b0;

    // =====================================================================
    // Holds
    always @(posedge clk_sys)
    begin
        holdPrev <= holdMode;
        noise <= ~noise;
        if (holdMode && !holdPrev)
            heldLevel <= levelIn;
    end

    // =====================================================================
    // Comparator
    // Outside a sequence the comparator wanders, so stale decisions show up
    always_comb
    begin
        if (holdMode)
            compHigh = heldLevel[muxSel] >= dacCode;
        else
            compHigh = noise;
    end
endmodule

`default_nettype wire

// ===== fcs_params.svh
// Constants for the four-channel sample sequencer
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH

// =====================================================================
// Clocking and timing
`define FCS_CLK_PERIOD_NS 10
`define FCS_SYS_CLK_HZ 100000000
`define FCS_CONV_CLK_HZ 2500000
`define FCS_CONV_DIV (`FCS_SYS_CLK_HZ / `FCS_CONV_CLK_HZ)
`define FCS_MAX_CONV_NS 32500
`define FCS_MAX_CONV_CYCLES (`FCS_MAX_CONV_NS / `FCS_CLK_PERIOD_NS)
`define FCS_SEQ_TICKS_MIN 78
`define FCS_SEQ_TICKS_MAX 79

// =====================================================================
// Sequence layout
`define FCS_RES_BITS 12
`define FCS_CHANNELS 4
`define FCS_CHAN_TICKS 19
`define FCS_SAR_FIRST_TICK 1
`define FCS_SAR_LAST_TICK 12
`define FCS_STORE_TICK 18
`define FCS_LAST_CHAN 2'h3

// =====================================================================
// Reset values and code points
`define FCS_TRIAL_START 12'h800
`define FCS_RESULT_RST 12'h000
`define FCS_MSB 11

`endif

// ===== fcs_pkg.sv
// Types shared by the sequencer and its converter core
`default_nettype none
`include "fcs_params.svh"

package fcs_pkg;

    typedef enum logic [1:0] {FCS_IDLE, FCS_ALIGN, FCS_CONVERT, FCS_FINISH} fcs_phase_t;

    typedef struct packed {
        logic busy;
        logic [3:0] idx;
        logic [`FCS_RES_BITS-1:0] trial;
        logic [`FCS_RES_BITS-1:0] code;
    } fcs_sar_t;

    typedef struct packed {
        fcs_phase_t phase;
        logic trigMeta;
        logic trigSync;
        logic trigPrev;
        logic csMeta;
        logic csSync;
        logic rdMeta;
        logic rdSync;
        logic rdPrev;
        logic cmpMeta;
        logic cmpSync;
        logic [7:0] divCnt;
        logic [4:0] tickCnt;
        logic [1:0] chan;
        logic [1:0] ptr;
        logic [`FCS_CHANNELS-1:0][`FCS_RES_BITS-1:0] results;
        logic readyN;
        logic hold;
        logic [`FCS_RES_BITS-1:0] busOut;
        logic busOe;
    } fcs_top_t;

endpackage

`default_nettype wire

// ===== fcs_sar.sv
// Successive-approximation core producing two's-complement codes
`default_nettype none
`include "fcs_params.svh"

module fcs_sar #(
    parameter int BITS = `FCS_RES_BITS
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic start, // Begin a new channel
    input wire logic step, // One conversion clock decision
    input wire logic compHigh, // Held input at or above trial level
    output logic [`FCS_RES_BITS-1:0] trialCode, // Trial level to the DAC
    output logic [`FCS_RES_BITS-1:0] code // Last finished code
);

    generate
        if (BITS != `FCS_RES_BITS)
        begin : g_bits_chk
            $error("fcs_sar supports only the fixed result width");
        end
    endgenerate

    fcs_pkg::fcs_sar_t sReg;
    fcs_pkg::fcs_sar_t sNext;
    logic [`FCS_RES_BITS-1:0] decided;

    // =================================================================
    // Bit decisions
    always_comb
    begin
        sNext = sReg;
        decided = sReg.trial;
        if (!compHigh)
        begin
            decided[sReg.idx] = 1'b0;
        end
        if (start)
        begin
            sNext.busy = 1'b1;
            sNext.idx = 4'(BITS - 1);
            sNext.trial = `FCS_TRIAL_START;
        end
        else if (step && sReg.busy)
        begin
            sNext.trial = decided;
            if (sReg.idx == 4'h0)
            begin
                sNext.busy = 1'b0;
                // Offset binary to two's complement: midscale becomes zero
                sNext.code = {~decided[`FCS_MSB], decided[`FCS_MSB-1:0]};
            end
            else
            begin
                sNext.trial[sReg.idx - 4'h1] = 1'b1;
                sNext.idx = sReg.idx - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sReg <= '0;
        end
        else
        begin
            sReg <= sNext;
        end
    end

    assign trialCode = sReg.trial;
    assign code = sReg.code;

endmodule

`default_nettype wire

// ===== fcs_sequencer.sv
// Four-channel simultaneous-sampling sequencer with implicit readout
//
// Overview of operation
// - Trigger rising edge starts a sequence
// - All four holds freeze on that edge
// - Channels convert in order one to four
// - Each channel result kept in own register
// - Ready flag falls after all four done
// - Sequence takes 78 or 79 conversion clocks
// - Trigger to ready within 32.5 us
// - Four reads at one address, internal pointer
// - Reads return channel one, two, three, four
// - No direct selection of a result register
// - Results are 12-bit two's complement words
// - Code changes all ones to zero at ground
// - Most positive code is 0111 1111 1111
// - Most negative code is 1000 0000 0000
// - Ready returns high on first read strobe fall
// - Trigger rising edge resets the read pointer
// - Outputs driven only with select and read low
`default_nettype none
`include "fcs_params.svh"

module fcs_sequencer #(
    parameter int CONV_DIV = `FCS_CONV_DIV
) (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic rst, // Async reset, active high
    input wire logic conversion_trigger_n, // Conversion trigger pin
    input wire logic chipSelectN, // Chip select pin
    input wire logic readStrobeN, // Read strobe pin
    input wire logic compHigh, // Comparator result pin
    output logic holdMode, // High while the four holds are frozen
    output logic [1:0] muxSel, // Channel under conversion
    output logic [`FCS_RES_BITS-1:0] dacCode, // Trial level
    output logic conversionDoneN, // Ready flag, low when results wait
    output logic [`FCS_RES_BITS-1:0] result_bus, // Read data
    output logic resultBusOe // Read data drive enable
);

    generate
        if (CONV_DIV < 2 || CONV_DIV > 256)
        begin : g_div_chk
            $error("CONV_DIV must lie between 2 and 256");
        end
    endgenerate

    fcs_pkg::fcs_top_t sReg;
    fcs_pkg::fcs_top_t sNext;
    logic tick;
    logic trigRise;
    logic rdFall;
    logic rdRise;
    logic sarStart;
    logic sarStep;
    logic [`FCS_RES_BITS-1:0] sarCode;

    assign tick = (sReg.divCnt == 8'(CONV_DIV - 1));
    assign trigRise = sReg.trigSync && !sReg.trigPrev;
    assign rdFall = sReg.rdPrev && !sReg.rdSync;
    assign rdRise = !sReg.rdPrev && sReg.rdSync;
    assign sarStart = tick && sReg.phase == fcs_pkg::FCS_CONVERT && sReg.tickCnt == 5'h0;
    assign sarStep = tick && sReg.phase == fcs_pkg::FCS_CONVERT
        && sReg.tickCnt >= 5'(`FCS_SAR_FIRST_TICK) && sReg.tickCnt <= 5'(`FCS_SAR_LAST_TICK);

    fcs_sar #(
        .BITS(`FCS_RES_BITS)
    ) fcs_sar_i (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(sarStart),
        .step(sarStep),
        .compHigh(sReg.cmpSync),
        .trialCode(dacCode),
        .code(sarCode)
    );

    // =================================================================
    // Next state
    always_comb
    begin
        sNext = sReg;
        // Pins cross into the clock domain through two flops each
        sNext.trigMeta = conversion_trigger_n;
        sNext.trigSync = sReg.trigMeta;
        sNext.trigPrev = sReg.trigSync;
        sNext.csMeta = chipSelectN;
        sNext.csSync = sReg.csMeta;
        sNext.rdMeta = readStrobeN;
        sNext.rdSync = sReg.rdMeta;
        sNext.rdPrev = sReg.rdSync;
        sNext.cmpMeta = compHigh;
        sNext.cmpSync = sReg.cmpMeta;
        sNext.divCnt = tick ? 8'h00 : sReg.divCnt + 8'h01;

        case (sReg.phase)
            fcs_pkg::FCS_IDLE:
            begin
                // A retrigger mid-sequence is the host's fault and is ignored
                if (trigRise)
                begin
                    sNext.phase = fcs_pkg::FCS_ALIGN;
                    sNext.hold = 1'b1;
                    sNext.ptr = 2'h0;
                    sNext.chan = 2'h0;
                    sNext.tickCnt = 5'h0;
                    sNext.readyN = 1'b1;
                end
            end
            fcs_pkg::FCS_ALIGN:
            begin
                // Waiting for the next clock tick gives the 78/79 spread
                if (tick)
                begin
                    sNext.phase = fcs_pkg::FCS_CONVERT;
                end
            end
            fcs_pkg::FCS_CONVERT:
            begin
                if (tick)
                begin
                    if (sReg.tickCnt == 5'(`FCS_STORE_TICK))
                    begin
                        sNext.results[sReg.chan] = sarCode;
                        sNext.tickCnt = 5'h0;
                        if (sReg.chan == `FCS_LAST_CHAN)
                        begin
                            sNext.phase = fcs_pkg::FCS_FINISH;
                        end
                        else
                        begin
                            sNext.chan = sReg.chan + 2'h1;
                        end
                    end
                    else
                    begin
                        sNext.tickCnt = sReg.tickCnt + 5'h1;
                    end
                end
            end
            fcs_pkg::FCS_FINISH:
            begin
                if (tick)
                begin
                    sNext.phase = fcs_pkg::FCS_IDLE;
                    sNext.hold = 1'b0;
                    sNext.readyN = 1'b0;
                end
            end
            default:
            begin
                sNext.phase = fcs_pkg::FCS_IDLE;
            end
        endcase

        // Readout only in idle so the pointer stays put while converting
        // A trigger in the same cycle wins, so the pointer rewind is never lost
        if (sReg.phase == fcs_pkg::FCS_IDLE && !sReg.csSync && !trigRise)
        begin
            if (rdFall)
            begin
                sNext.readyN = 1'b1;
            end
            if (rdRise)
            begin
                sNext.ptr = sReg.ptr + 2'h1;
            end
        end
        sNext.busOe = !sReg.csSync && !sReg.rdSync;
        // Only the pointer picks the word; there is no address input
        sNext.busOut = sReg.results[sReg.ptr];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sReg <= '0;
            sReg.phase <= fcs_pkg::FCS_IDLE;
            sReg.trigMeta <= 1'b1;
            sReg.trigSync <= 1'b1;
            sReg.trigPrev <= 1'b1;
            sReg.csMeta <= 1'b1;
            sReg.csSync <= 1'b1;
            sReg.rdMeta <= 1'b1;
            sReg.rdSync <= 1'b1;
            sReg.rdPrev <= 1'b1;
            sReg.readyN <= 1'b1;
        end
        else
        begin
            sReg <= sNext;
        end
    end

    assign holdMode = sReg.hold;
    assign muxSel = sReg.chan;
    assign conversionDoneN = sReg.readyN;
    assign result_bus = sReg.busOut;
    assign resultBusOe = sReg.busOe;

    // =================================================================
    // Checks
    // Limit scales with the conversion clock divide
    localparam int MaxCycles = (`FCS_MAX_CONV_NS * CONV_DIV) / (`FCS_CLK_PERIOD_NS * `FCS_CONV_DIV);
    logic [15:0] elapsedReg;
    logic [6:0] ticksReg;
    logic seqOn;
    assign seqOn = sReg.phase != fcs_pkg::FCS_IDLE;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            elapsedReg <= 16'h0000;
            ticksReg <= 7'h00;
        end
        else
        begin
            elapsedReg <= seqOn ? elapsedReg + 16'h0001 : 16'h0000;
            ticksReg <= seqOn ? ticksReg + 7'(tick) : 7'h00;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    hold_on_trigger_a: assert property (
        sReg.phase == fcs_pkg::FCS_IDLE && trigRise |=> holdMode && sReg.ptr == 2'h0 ##1 holdMode)
        else $error("holds did not freeze on trigger");
    pointer_reset_a: assert property (
        sReg.phase == fcs_pkg::FCS_IDLE && trigRise |=> sReg.ptr == 2'h0 && muxSel == 2'h0)
        else $error("pointer not reset by trigger");
    channel_order_a: assert property (
        seqOn && $changed(muxSel) |-> muxSel == $past(muxSel) + 2'h1)
        else $error("channel order broken");
    result_store_a: assert property (
        sReg.phase == fcs_pkg::FCS_CONVERT && tick && sReg.tickCnt == 5'(`FCS_STORE_TICK)
        |=> sReg.results[$past(sReg.chan)] == $past(sarCode))
        else $error("result not stored");
    ready_after_all_a: assert property (
        $fell(conversionDoneN) |-> $past(sReg.phase) == fcs_pkg::FCS_FINISH && muxSel == 2'h3)
        else $error("ready fell early");
    tick_count_a: assert property (
        $fell(conversionDoneN) |-> $past(ticksReg) + 7'(tick) >= 7'(`FCS_SEQ_TICKS_MIN - 1)
        && $past(ticksReg) <= 7'(`FCS_SEQ_TICKS_MAX))
        else $error("sequence tick count wrong");
    time_limit_a: assert property (
        seqOn |-> elapsedReg < 16'(MaxCycles))
        else $error("conversion too long");
    ready_clear_a: assert property (
        !conversionDoneN && !sReg.csSync && rdFall |=> conversionDoneN)
        else $error("ready not cleared by read");
    drive_enable_a: assert property (
        resultBusOe |-> $past(!sReg.csSync) && $past(!sReg.rdSync))
        else $error("bus driven without select and read");
    pointer_hold_a: assert property (
        seqOn && sReg.phase != fcs_pkg::FCS_ALIGN |-> $stable(sReg.ptr))
        else $error("pointer moved while converting");
    read_order_a: assert property (
        sReg.phase == fcs_pkg::FCS_IDLE && !sReg.csSync && rdRise && !trigRise
        |=> sReg.ptr == $past(sReg.ptr) + 2'h1)
        else $error("pointer not advanced by read");

    // Elapsed counter stands in for a long delay range from trigger to ready
    full_sequence_c: cover property ($fell(conversionDoneN) && $past(elapsedReg) != 16'h0000);
    first_read_c: cover property ($fell(conversionDoneN) ##[1:200] rdFall && !sReg.csSync);
    four_reads_c: cover property (sReg.ptr == 2'h3 ##[1:200] sReg.ptr == 2'h0);
    retrigger_c: cover property (seqOn && trigRise);

endmodule

`default_nettype wire

// ===== fcs_sequencer_test.sv
// Self-checking bench for the four-channel sample sequencer
`default_nettype none
`include "fcs_params.svh"

module fcs_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Wiring
    localparam int W = `FCS_RES_BITS;
    localparam int DIV = 4; // Short conversion clock keeps runs small
    localparam int DONE_MAX = (8125 * DIV) / 100;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic convTrigN = 1'b1;
    logic csN = 1'b1;
    logic rdN = 1'b1;
    logic compHigh;
    logic holdMode;
    logic [1:0] muxSel;
    logic [W-1:0] dacCode;
    logic doneN;
    logic [W-1:0] resultBus;
    logic resultBusOe;
    logic [3:0][W-1:0] levelIn = '0;
    logic [31:0] rngState = 32'h611e_a96a;
    logic [W-1:0] expCode [4];
    logic [1:0] muxTrace [$];
    int fail_count = 0;
    int n_checks = 0;

    initial forever #5 clk_sys = ~clk_sys;

    fcs_sequencer #(.CONV_DIV(DIV)) fcs_sequencer_i (
        .clk_sys(clk_sys), .rst(rst), .conversion_trigger_n(convTrigN),
        .chipSelectN(csN), .readStrobeN(rdN), .compHigh(compHigh),
        .holdMode(holdMode), .muxSel(muxSel), .dacCode(dacCode),
        .conversionDoneN(doneN), .result_bus(resultBus), .resultBusOe(resultBusOe)
    );

    fcs_front_model fcs_front_model_i (
        .clk_sys(clk_sys), .holdMode(holdMode), .muxSel(muxSel),
        .dacCode(dacCode), .levelIn(levelIn), .compHigh(compHigh)
    );

    // =====================================================================
    // Helpers
    function automatic logic [W-1:0] rand_level();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState[W-1:0];
    endfunction

    // Offset-binary level to two's complement: flip the sign bit
    function automatic logic [W-1:0] to_code(input logic [W-1:0] lv);
        return lv ^ 12'h800;
    endfunction

    task automatic check(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic read_word(input logic selN, input logic [W-1:0] exp, input logic expOe);
        @(negedge clk_sys);
        csN = selN;
        rdN = 1'b0;
        repeat (5) @(negedge clk_sys);
        check("bus enable", {11'h000, expOe}, {11'h000, resultBusOe});
        if (expOe)
            check("result word", exp, resultBus);
        rdN = 1'b1;
        repeat (5) @(negedge clk_sys);
        check("bus release", 12'h000, {11'h000, resultBusOe});
        csN = 1'b1;
    endtask

    // Stray trigger and read mid-sequence are host faults the block must ignore
    task automatic run_seq(input logic [3:0][W-1:0] lv);
        int t;
        int h;
        levelIn = lv;
        for (int c = 0; c < 4; c++)
            expCode[c] = to_code(lv[c]);
        muxTrace.delete();
        t = 0;
        h = 0;
        @(negedge clk_sys);
        convTrigN = 1'b0;
        repeat (3) @(negedge clk_sys);
        convTrigN = 1'b1;
        while (doneN !== 1'b0 && t < 1000)
        begin
            @(negedge clk_sys);
            t++;
            if (holdMode === 1'b1)
                h++;
            if (holdMode === 1'b1 && (muxTrace.size() == 0 || muxTrace[$] !== muxSel))
                muxTrace.push_back(muxSel);
            if (t == 20)
                levelIn = ~lv;
            convTrigN = !(t >= 30 && t < 34);
            csN = !(t >= 40 && t < 60);
            rdN = !(t >= 44 && t < 52);
        end
        check("trigger to ready", 12'h001, {11'h000, t <= DONE_MAX});
        check("hold span", 12'h001, {11'h000, h >= 77 * DIV && h <= 79 * DIV});
        check("hold released", 12'h000, {11'h000, holdMode});
        check("channel count", 12'h004, 12'(muxTrace.size()));
        foreach (muxTrace[k])
            check("channel order", 12'(k), {10'h000, muxTrace[k]});
    endtask

    // =====================================================================
    // Main sequence
    initial
    begin
        logic [3:0][W-1:0] lv;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        check("ready idle", 12'h001, {11'h000, doneN});
        for (int i = 0; i < 12; i++)
        begin
            if (i == 0)
                lv = {12'h000, 12'hfff, 12'h7ff, 12'h800};
            else if (i == 1)
                lv = {12'h7fe, 12'h800, 12'hffe, 12'h001};
            else
                for (int c = 0; c < 4; c++)
                    lv[c] = rand_level();
            run_seq(lv);
            check("ready low", 12'h000, {11'h000, doneN});
            read_word(1'b0, expCode[0], 1'b1);
            check("ready after read", 12'h001, {11'h000, doneN});
            read_word(1'b0, expCode[1], 1'b1);
            // Odd passes stop early so the next trigger must rewind the pointer
            if (i % 2 == 0)
            begin
                read_word(1'b0, expCode[2], 1'b1);
                read_word(1'b0, expCode[3], 1'b1);
                read_word(1'b1, 12'h000, 1'b0);
                read_word(1'b0, expCode[0], 1'b1);
            end
        end
        end_sim();
    end

    // =====================================================================
    // Watchdog, about five times the expected run
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("ERROR watchdog expected finish seen hang");
        end_sim();
    end
endmodule

`default_nettype wire
